// ==== include/hps_pkg.sv ====
// Shared constants of the haptic pulse sequencer
package hps_pkg;
	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_DEVICE_CONTROL = 8'h00;
	localparam logic [7:0] OFS_CLOCK_SELECT = 8'h01;
	localparam logic [7:0] OFS_PULSE_TIMING_FIRST = 8'h02;
	localparam logic [7:0] OFS_PULSE_TIMING_SECOND = 8'h03;
	localparam logic [7:0] OFS_HAPTIC_SUPPLY_LEVEL = 8'h04;
	localparam logic [7:0] OFS_VIBRATE_SUPPLY_LEVEL = 8'h05;
	// ---------------------------------------------------------------
	// Reset values and writable masks
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_DEVICE_CONTROL = 8'h01;
	localparam logic [7:0] RST_CLOCK_SELECT = 8'h00;
	localparam logic [7:0] RST_PULSE_TIMING_FIRST = 8'h0a;
	localparam logic [7:0] RST_PULSE_TIMING_SECOND = 8'h85;
	localparam logic [7:0] RST_HAPTIC_SUPPLY_LEVEL = 8'h00;
	localparam logic [7:0] RST_VIBRATE_SUPPLY_LEVEL = 8'h1a;
	localparam logic [7:0] MASK_DEVICE_CONTROL = 8'h17;
	localparam logic [7:0] MASK_CLOCK_SELECT = 8'h0f;
	localparam logic [7:0] MASK_SUPPLY_LEVEL = 8'h1f;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int BIT_DEVICE_ENABLE = 0;
	localparam int BIT_HAPTIC_TRIGGER = 1;
	localparam int BIT_VIBRATE_ENABLE = 2;
	localparam int BIT_OVERHEAT_LATCH = 3;
	localparam int BIT_SEQUENCE_REPEAT = 4;
	localparam int BIT_EXTERNAL_CLOCK_SELECT = 0;
	localparam int BIT_CLOCK_HALVE = 1;
	localparam int BIT_CLOCK_QUARTER = 2;
	localparam int BIT_CLOCK_SIXTEENTH = 3;
	// ---------------------------------------------------------------
	// Serial port and timing
	// ---------------------------------------------------------------
	localparam logic [6:0] SERIAL_ADDRESS = 7'h66;
	localparam int CLK_PERIOD_NS = 40;
	localparam int INT_TICK_NS = 1000000;
	localparam int WDOG_TIMEOUT_NS = 8000000;
	localparam int INT_TICK_CYCLES = INT_TICK_NS / CLK_PERIOD_NS;
	localparam int WDOG_TIMEOUT_CYCLES = WDOG_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int PHASE_STEP_SHORT = 1;
	localparam int PHASE_STEP_LONG = 2;
endpackage

// ==== rtl/hps_timebase.sv ====
// Timer clock source selection, divider and external clock watchdog
`timescale 1ns/10ps
module hps_timebase #(
	parameter int TICK_CYCLES = hps_pkg::INT_TICK_CYCLES,
	parameter int WDOG_CYCLES = hps_pkg::WDOG_TIMEOUT_CYCLES
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic ext_clock_in,
	input wire logic ext_select_in,
	input wire logic [2:0] divide_bits_in,
	output logic timer_tick_out,
	output logic wdog_expired_out
);
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam int WDOG_W = $clog2(WDOG_CYCLES + 1);

	// ---------------------------------------------------------------
	// Source ticks
	// ---------------------------------------------------------------
	logic ext_meta;
	logic ext_stable;
	logic ext_prev;
	logic [TICK_W-1:0] int_count;
	logic [WDOG_W-1:0] wdog_count;
	logic [7:0] div_count;
	wire ext_rise = ext_stable & ~ext_prev;
	wire int_wrap = (int_count == TICK_W'(TICK_CYCLES - 1));
	wire src_tick = ext_select_in ? ext_rise : int_wrap;
	wire [2:0] div_shift = {2'b00, divide_bits_in[0]} + {1'b0, divide_bits_in[1], 1'b0}
		+ {divide_bits_in[2], 2'b00};
	wire [7:0] div_limit = 8'((8'h01 << div_shift) - 8'h01);
	wire div_wrap = (div_count >= div_limit);
	wire wdog_hit = (wdog_count >= WDOG_W'(WDOG_CYCLES));

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ext_meta <= 1'b0;
			ext_stable <= 1'b0;
			ext_prev <= 1'b0;
		end
		else
		begin
			ext_meta <= ext_clock_in;
			ext_stable <= ext_meta;
			ext_prev <= ext_stable;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			int_count <= '0;
		else if (int_wrap)
			int_count <= '0;
		else
			int_count <= int_count + 1'b1;
	end

	// ---------------------------------------------------------------
	// Divider
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			div_count <= 8'h00;
			timer_tick_out <= 1'b0;
		end
		else
		begin
			timer_tick_out <= src_tick & div_wrap;
			if (src_tick)
				div_count <= div_wrap ? 8'h00 : div_count + 8'h01;
		end
	end

	// ---------------------------------------------------------------
	// Watchdog, only armed while the external clock is selected
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			wdog_count <= '0;
			wdog_expired_out <= 1'b0;
		end
		else
		begin
			if (!ext_select_in || ext_rise)
				wdog_count <= '0;
			else if (!wdog_hit)
				wdog_count <= wdog_count + 1'b1;
			wdog_expired_out <= ext_select_in & wdog_hit;
		end
	end
endmodule

// ==== rtl/hps_core.sv ====
// Haptic pulse sequencer: serial register slave and phase sequencer
`timescale 1ns/10ps
// Functional notes
// - Six 8-bit registers, readable and writable over the two-wire slave port.
// - Every register takes its default value at reset.
// - Each rising trigger edge in idle starts one sequence; a held level does not.
// - During a haptic sequence the supply code comes from the haptic level.
// - Vibrate enable with no sequence drives forward on the vibrate level.
// - Device enable at zero means standby; trigger and vibrate are ignored.
// - Clock select picks internal oscillator or external clock pin for timers.
// - Timer clock divides by product of enabled by-2, by-4, by-16 bits.
// - Forward, coast and reverse last twice their code in timer cycles.
// - Recovery lasts four times its code in timer cycles.
// - No new pulse starts before recovery ends; early edges are dropped.
// - Overheat sets a read-only latch cleared only by the reset pin.
// - Thermal or undervoltage fault disables the device until it clears.
// - Default timing forward 20, coast 0, reverse 10, recovery 32 cycles.
// - Default haptic supply is direct input, vibrate supply is 2.5 V.
// - Default enabled, internal oscillator, no division, 1 ms timer cycle.
// - Coast releases both bridge outputs at once.
// - Repeat set and enabled restarts the sequence after each recovery.
// - External clock gaps beyond the watchdog abort a running sequence.
// - Reset pin low holds defaults, shuts down and refuses serial access.
module hps_core #(
	parameter int TICK_CYCLES = hps_pkg::INT_TICK_CYCLES,
	parameter int WDOG_CYCLES = hps_pkg::WDOG_TIMEOUT_CYCLES
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic haptic_trigger_in,
	input wire logic vibrate_enable_in,
	input wire logic external_clock_input_in,
	input wire logic over_temp_in,
	input wire logic under_voltage_in,
	output logic bridge_output_plus_out,
	output logic bridge_output_plus_oe_out,
	output logic bridge_output_minus_out,
	output logic bridge_output_minus_oe_out,
	output logic supply_on_out,
	output logic supply_direct_out,
	output logic [4:0] supply_code_out
);
	typedef enum logic [2:0] {
		SQ_IDLE,
		SQ_FORWARD,
		SQ_COAST,
		SQ_REVERSE,
		SQ_RECOVERY
	} hps_seq_state_type;

	typedef enum logic [2:0] {
		SL_IDLE,
		SL_RECEIVE,
		SL_ACK,
		SL_SEND,
		SL_MASTER_ACK
	} hps_serial_state_type;

	typedef enum logic [1:0] {
		BK_ADDRESS,
		BK_POINTER,
		BK_DATA
	} hps_byte_kind_type;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	localparam int NPIN = 6;
	wire [NPIN-1:0] pin_raw = {under_voltage_in, over_temp_in, vibrate_enable_in,
		haptic_trigger_in, sda_in, scl_in};
	logic [NPIN-1:0] pin_meta;
	logic [NPIN-1:0] pin_sync;

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++)
		begin : g_sync
			always_ff @(posedge clk_sys_in or negedge resetn_in)
			begin
				if (!resetn_in)
				begin
					pin_meta[gi] <= (gi < 2);
					pin_sync[gi] <= (gi < 2);
				end
				else
				begin
					pin_meta[gi] <= pin_raw[gi];
					pin_sync[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	wire scl_s = pin_sync[0];
	wire sda_s = pin_sync[1];
	wire trig_pin = pin_sync[2];
	wire vib_pin = pin_sync[3];
	wire temp_fault = pin_sync[4];
	wire volt_fault = pin_sync[5];

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0] device_control;
	logic [7:0] clock_select;
	logic [7:0] pulse_timing_first;
	logic [7:0] pulse_timing_second;
	logic [7:0] haptic_supply_level;
	logic [7:0] vibrate_supply_level;
	logic overheat_latch;
	logic reg_write;
	logic [7:0] reg_pointer;
	logic [7:0] shift_byte;

	wire wr_ctrl = reg_write && reg_pointer == hps_pkg::OFS_DEVICE_CONTROL;
	wire wr_clk = reg_write && reg_pointer == hps_pkg::OFS_CLOCK_SELECT;
	wire wr_tim1 = reg_write && reg_pointer == hps_pkg::OFS_PULSE_TIMING_FIRST;
	wire wr_tim2 = reg_write && reg_pointer == hps_pkg::OFS_PULSE_TIMING_SECOND;
	wire wr_hsup = reg_write && reg_pointer == hps_pkg::OFS_HAPTIC_SUPPLY_LEVEL;
	wire wr_vsup = reg_write && reg_pointer == hps_pkg::OFS_VIBRATE_SUPPLY_LEVEL;

	// Writes of all six registers, control latch bit excluded
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			device_control <= hps_pkg::RST_DEVICE_CONTROL;
			clock_select <= hps_pkg::RST_CLOCK_SELECT;
			pulse_timing_first <= hps_pkg::RST_PULSE_TIMING_FIRST;
			pulse_timing_second <= hps_pkg::RST_PULSE_TIMING_SECOND;
			haptic_supply_level <= hps_pkg::RST_HAPTIC_SUPPLY_LEVEL;
			vibrate_supply_level <= hps_pkg::RST_VIBRATE_SUPPLY_LEVEL;
		end
		else
		begin
			if (wr_ctrl)
				device_control <= shift_byte & hps_pkg::MASK_DEVICE_CONTROL;
			if (wr_clk)
				clock_select <= shift_byte & hps_pkg::MASK_CLOCK_SELECT;
			if (wr_tim1)
				pulse_timing_first <= shift_byte;
			if (wr_tim2)
				pulse_timing_second <= shift_byte;
			if (wr_hsup)
				haptic_supply_level <= shift_byte & hps_pkg::MASK_SUPPLY_LEVEL;
			if (wr_vsup)
				vibrate_supply_level <= shift_byte & hps_pkg::MASK_SUPPLY_LEVEL;
		end
	end

	// Only the reset pin clears it; host writes never reach it
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			overheat_latch <= 1'b0;
		else if (temp_fault)
			overheat_latch <= 1'b1;
	end

	wire [7:0] read_byte =
		(reg_pointer == hps_pkg::OFS_DEVICE_CONTROL) ?
			(device_control | {4'h0, overheat_latch, 3'b000}) :
		(reg_pointer == hps_pkg::OFS_CLOCK_SELECT) ? clock_select :
		(reg_pointer == hps_pkg::OFS_PULSE_TIMING_FIRST) ? pulse_timing_first :
		(reg_pointer == hps_pkg::OFS_PULSE_TIMING_SECOND) ? pulse_timing_second :
		(reg_pointer == hps_pkg::OFS_HAPTIC_SUPPLY_LEVEL) ? haptic_supply_level :
		(reg_pointer == hps_pkg::OFS_VIBRATE_SUPPLY_LEVEL) ? vibrate_supply_level :
		8'h00;

	// ---------------------------------------------------------------
	// Two-wire slave
	// ---------------------------------------------------------------
	hps_serial_state_type sl_state;
	hps_byte_kind_type byte_kind;
	logic scl_prev;
	logic sda_prev;
	logic [3:0] bit_count;
	logic read_mode;
	logic master_ack;
	logic [7:0] tx_byte;

	wire scl_rise = scl_s & ~scl_prev;
	wire scl_fall = ~scl_s & scl_prev;
	wire start_cond = scl_s & scl_prev & sda_prev & ~sda_s;
	wire stop_cond = scl_s & scl_prev & ~sda_prev & sda_s;
	wire byte_done = (bit_count == 4'h8);
	wire addr_match = (shift_byte[7:1] == hps_pkg::SERIAL_ADDRESS);

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end
		else
		begin
			scl_prev <= scl_s;
			sda_prev <= sda_s;
		end
	end

	// Reset pin low keeps this idle, so no access is answered
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			sl_state <= SL_IDLE;
			byte_kind <= BK_ADDRESS;
			bit_count <= 4'h0;
			shift_byte <= 8'h00;
			tx_byte <= 8'h00;
			reg_pointer <= 8'h00;
			read_mode <= 1'b0;
			master_ack <= 1'b0;
			reg_write <= 1'b0;
			sda_out <= 1'b0;
			sda_oe_out <= 1'b0;
		end
		else
		begin
			reg_write <= 1'b0;
			sda_out <= 1'b0;
			if (start_cond)
			begin
				sl_state <= SL_RECEIVE;
				byte_kind <= BK_ADDRESS;
				bit_count <= 4'h0;
				sda_oe_out <= 1'b0;
			end
			else if (stop_cond)
			begin
				sl_state <= SL_IDLE;
				sda_oe_out <= 1'b0;
			end
			else
			begin
				unique case (sl_state)
					SL_IDLE:
						sda_oe_out <= 1'b0;
					SL_RECEIVE:
						if (scl_rise && !byte_done)
						begin
							shift_byte <= {shift_byte[6:0], sda_s};
							bit_count <= bit_count + 4'h1;
						end
						else if (scl_fall && byte_done)
						begin
							sl_state <= SL_ACK;
							sda_oe_out <= 1'b1;
							unique case (byte_kind)
								BK_ADDRESS:
									if (addr_match)
										read_mode <= shift_byte[0];
									else
									begin
										sl_state <= SL_IDLE;
										sda_oe_out <= 1'b0;
									end
								BK_POINTER:
									reg_pointer <= shift_byte;
								BK_DATA:
									reg_write <= 1'b1;
								default:
									sl_state <= SL_IDLE;
							endcase
						end
					SL_ACK:
						if (scl_fall)
						begin
							bit_count <= 4'h0;
							if (read_mode && byte_kind == BK_ADDRESS)
							begin
								sl_state <= SL_SEND;
								tx_byte <= {read_byte[6:0], 1'b0};
								sda_oe_out <= ~read_byte[7];
							end
							else
							begin
								sl_state <= SL_RECEIVE;
								sda_oe_out <= 1'b0;
								byte_kind <= (byte_kind == BK_ADDRESS) ? BK_POINTER : BK_DATA;
							end
						end
					SL_SEND:
						if (scl_fall)
						begin
							bit_count <= bit_count + 4'h1;
							if (bit_count == 4'h7)
							begin
								sl_state <= SL_MASTER_ACK;
								sda_oe_out <= 1'b0;
							end
							else
							begin
								sda_oe_out <= ~tx_byte[7];
								tx_byte <= {tx_byte[6:0], 1'b0};
							end
						end
					SL_MASTER_ACK:
						if (scl_rise)
							master_ack <= ~sda_s;
						else if (scl_fall)
						begin
							bit_count <= 4'h0;
							if (master_ack)
							begin
								sl_state <= SL_SEND;
								tx_byte <= {read_byte[6:0], 1'b0};
								sda_oe_out <= ~read_byte[7];
							end
							else
								sl_state <= SL_IDLE;
						end
					default:
						sl_state <= SL_IDLE;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Timer clock
	// ---------------------------------------------------------------
	logic timer_tick;
	logic wdog_expired;

	hps_timebase #(
		.TICK_CYCLES(TICK_CYCLES),
		.WDOG_CYCLES(WDOG_CYCLES)
	) u_timebase (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.ext_clock_in(external_clock_input_in),
		.ext_select_in(clock_select[hps_pkg::BIT_EXTERNAL_CLOCK_SELECT]),
		.divide_bits_in(clock_select[hps_pkg::BIT_CLOCK_SIXTEENTH:hps_pkg::BIT_CLOCK_HALVE]),
		.timer_tick_out(timer_tick),
		.wdog_expired_out(wdog_expired)
	);

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	hps_seq_state_type seq_state;
	hps_seq_state_type next_seq_state;
	logic [5:0] seq_count;
	logic [5:0] next_seq_count;
	logic trig_prev;

	// Faults gate the device only while present
	wire device_active = device_control[hps_pkg::BIT_DEVICE_ENABLE]
		& ~temp_fault & ~volt_fault;
	wire trig_eff = trig_pin | device_control[hps_pkg::BIT_HAPTIC_TRIGGER];
	wire vib_eff = vib_pin | device_control[hps_pkg::BIT_VIBRATE_ENABLE];
	wire repeat_on = device_control[hps_pkg::BIT_SEQUENCE_REPEAT];
	wire ext_lost = clock_select[hps_pkg::BIT_EXTERNAL_CLOCK_SELECT] & wdog_expired;
	wire trig_rise = trig_eff & ~trig_prev;
	wire start_req = device_active & ~ext_lost & (trig_rise | repeat_on);
	wire [5:0] fwd_len = {1'b0, pulse_timing_first[3:0], 1'b0};
	wire [5:0] coast_len = {1'b0, pulse_timing_first[7:4], 1'b0};
	wire [5:0] rev_len = {1'b0, pulse_timing_second[3:0], 1'b0};
	wire [5:0] rec_len = {pulse_timing_second[7:4], 2'b00};
	wire phase_over = (seq_count == 6'h00);

	always_comb
	begin
		next_seq_state = seq_state;
		next_seq_count = seq_count;
		unique case (seq_state)
			SQ_IDLE:
				if (start_req)
				begin
					next_seq_state = SQ_FORWARD;
					next_seq_count = fwd_len;
				end
			SQ_FORWARD:
				if (phase_over)
				begin
					next_seq_state = SQ_COAST;
					next_seq_count = coast_len;
				end
			SQ_COAST:
				if (phase_over)
				begin
					next_seq_state = SQ_REVERSE;
					next_seq_count = rev_len;
				end
			SQ_REVERSE:
				if (phase_over)
				begin
					next_seq_state = SQ_RECOVERY;
					next_seq_count = rec_len;
				end
			SQ_RECOVERY:
				if (phase_over && repeat_on && device_active)
				begin
					next_seq_state = SQ_FORWARD;
					next_seq_count = fwd_len;
				end
				else if (phase_over)
					next_seq_state = SQ_IDLE;
		endcase
		if (seq_state != SQ_IDLE && !phase_over && timer_tick)
			next_seq_count = seq_count - 6'h01;
		if (seq_state != SQ_IDLE && (!device_active || ext_lost))
		begin
			next_seq_state = SQ_IDLE;
			next_seq_count = 6'h00;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			seq_state <= SQ_IDLE;
			seq_count <= 6'h00;
			trig_prev <= 1'b0;
		end
		else
		begin
			seq_state <= next_seq_state;
			seq_count <= next_seq_count;
			trig_prev <= trig_eff;
		end
	end

	// ---------------------------------------------------------------
	// Bridge and supply drive
	// ---------------------------------------------------------------
	// Recovery keeps the haptic level selected but the bridge released
	wire haptic_on = (seq_state != SQ_IDLE);
	wire vib_drive = ~haptic_on & vib_eff & device_active;
	wire drive_fwd = (seq_state == SQ_FORWARD) | vib_drive;
	wire drive_rev = (seq_state == SQ_REVERSE);
	wire [4:0] next_code = haptic_on ? haptic_supply_level[4:0]
		: vibrate_supply_level[4:0];

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			bridge_output_plus_out <= 1'b0;
			bridge_output_plus_oe_out <= 1'b0;
			bridge_output_minus_out <= 1'b0;
			bridge_output_minus_oe_out <= 1'b0;
			supply_on_out <= 1'b0;
			supply_direct_out <= 1'b0;
			supply_code_out <= 5'h00;
		end
		else
		begin
			bridge_output_plus_out <= drive_fwd;
			bridge_output_minus_out <= drive_rev;
			bridge_output_plus_oe_out <= drive_fwd | drive_rev;
			bridge_output_minus_oe_out <= drive_fwd | drive_rev;
			supply_on_out <= haptic_on | vib_drive;
			supply_direct_out <= (haptic_on | vib_drive) && next_code == 5'h00;
			supply_code_out <= next_code;
		end
	end
endmodule

// ==== sim/hps_host.sv ====
// Two-wire host model for the register port
`timescale 1ns/10ps
module hps_host (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_low_out
);
	initial
	begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	// Each SCL phase is 6 clk, above the 4 clk floor of the slave
	task automatic hold(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic clk_bit(input logic b, output logic r);
		sda_low_out = !b;
		hold(6);
		scl_out = 1'b1;
		hold(6);
		r = sda_in;
		scl_out = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, output logic [7:0] q);
		logic k;
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], q[i]);
		clk_bit(1'b1, k);
	endtask
	task automatic start();
		sda_low_out = 1'b0;
		hold(6);
		scl_out = 1'b1;
		hold(6);
		sda_low_out = 1'b1;
		hold(6);
		scl_out = 1'b0;
	endtask
	task automatic stop();
		sda_low_out = 1'b1;
		hold(6);
		scl_out = 1'b1;
		hold(6);
		sda_low_out = 1'b0;
		hold(6);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		start();
		xfer({hps_pkg::SERIAL_ADDRESS, 1'b0}, q);
		xfer(a, q);
		xfer(d, q);
		stop();
	endtask
	// Last data bit is followed by a released SDA, so the slave sees a NACK
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] q;
		start();
		xfer({hps_pkg::SERIAL_ADDRESS, 1'b0}, q);
		xfer(a, q);
		start();
		xfer({hps_pkg::SERIAL_ADDRESS, 1'b1}, q);
		xfer(8'hff, d);
		stop();
	endtask
endmodule

// ==== sim/hps_core_chk.sv ====
// Port assertions of the haptic pulse sequencer
`timescale 1ns/10ps
module hps_core_chk (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic scl_in,
	input wire logic over_temp_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic bridge_output_plus_out,
	input wire logic bridge_output_plus_oe_out,
	input wire logic bridge_output_minus_out,
	input wire logic bridge_output_minus_oe_out,
	input wire logic supply_on_out,
	input wire logic supply_direct_out,
	input wire logic [4:0] supply_code_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	chk_legs_together:
	assert property (bridge_output_plus_oe_out == bridge_output_minus_oe_out)
		else $error("bridge legs enabled apart");
	chk_legs_opposed:
	assert property (bridge_output_plus_oe_out |-> bridge_output_plus_out != bridge_output_minus_out)
		else $error("bridge legs drive same level");
	chk_supply_drive:
	assert property (bridge_output_plus_oe_out |-> supply_on_out)
		else $error("bridge driven with supply off");
	chk_direct_code:
	assert property (supply_direct_out == (supply_on_out && supply_code_out == 5'h00))
		else $error("direct supply flag wrong");
	chk_fault_stop:
	assert property (over_temp_in [*6] |-> !bridge_output_plus_oe_out)
		else $error("bridge driven during fault");
	chk_reset_quiet:
	assert property (disable iff (1'b0)
		!resetn_in |-> !bridge_output_plus_oe_out && !sda_oe_out && !supply_on_out)
		else $error("outputs active in reset");
	chk_sda_low:
	assert property (sda_oe_out |-> !sda_out)
		else $error("data line driven high");
	chk_ack_scl_low:
	assert property ($rose(sda_oe_out) |-> !scl_in)
		else $error("data line changed with clock high");
endmodule
bind hps_core hps_core_chk i_chk (
	.clk_sys_in(clk_sys_in),
	.resetn_in(resetn_in),
	.scl_in(scl_in),
	.over_temp_in(over_temp_in),
	.sda_out(sda_out),
	.sda_oe_out(sda_oe_out),
	.bridge_output_plus_out(bridge_output_plus_out),
	.bridge_output_plus_oe_out(bridge_output_plus_oe_out),
	.bridge_output_minus_out(bridge_output_minus_out),
	.bridge_output_minus_oe_out(bridge_output_minus_oe_out),
	.supply_on_out(supply_on_out),
	.supply_direct_out(supply_direct_out),
	.supply_code_out(supply_code_out)
);

// ==== sim/hps_core_bench.sv ====
// Self-checking bench of the haptic pulse sequencer
`timescale 1ns/10ps
module hps_core_bench;
	localparam int TK = 10;
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b1;
	logic trig = 1'b0;
	logic vib = 1'b0;
	logic ot = 1'b0;
	logic uv = 1'b0;
	logic xc = 1'b0;
	logic xrun = 1'b0;
	logic scl;
	logic sda_low;
	logic sda_oe;
	logic sda_w;
	logic p_oe;
	logic p;
	logic m;
	logic [2:0] prev = 3'b000;
	int run = 0;
	int miscompares = 0;
	int n_tests = 0;
	int tol = TK + 2;
	int cyc = 0;
	logic [31:0] lfsr = 32'heabc;
	logic [7:0] got;
	logic [7:0] rd_q[$];
	int len_q[$];
	event rd_ev;
	logic [7:0] dflt[6] = '{hps_pkg::RST_DEVICE_CONTROL, hps_pkg::RST_CLOCK_SELECT,
		hps_pkg::RST_PULSE_TIMING_FIRST, hps_pkg::RST_PULSE_TIMING_SECOND,
		hps_pkg::RST_HAPTIC_SUPPLY_LEVEL, hps_pkg::RST_VIBRATE_SUPPLY_LEVEL};
	logic [7:0] msk[6] = '{hps_pkg::MASK_DEVICE_CONTROL, hps_pkg::MASK_CLOCK_SELECT, 8'hff,
		8'hff, hps_pkg::MASK_SUPPLY_LEVEL, hps_pkg::MASK_SUPPLY_LEVEL};
	// Open-drain data line with pull-up
	assign sda_w = !(sda_low || sda_oe);
	always #20 clk_sys_in = !clk_sys_in;
	hps_core #(.TICK_CYCLES(TK), .WDOG_CYCLES(40)) i_dut (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.scl_in(scl),
		.sda_in(sda_w),
		.sda_out(),
		.sda_oe_out(sda_oe),
		.haptic_trigger_in(trig),
		.vibrate_enable_in(vib),
		.external_clock_input_in(xc),
		.over_temp_in(ot),
		.under_voltage_in(uv),
		.bridge_output_plus_out(p),
		.bridge_output_plus_oe_out(p_oe),
		.bridge_output_minus_out(m),
		.bridge_output_minus_oe_out(),
		.supply_on_out(),
		.supply_direct_out(),
		.supply_code_out()
	);
	hps_host i_host (
		.clk_in(clk_sys_in),
		.sda_in(sda_w),
		.scl_out(scl),
		.sda_low_out(sda_low)
	);
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic give_verdict();
		if (rd_q.size() + len_q.size() != 0)
			miscompares++;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic hold(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic cmp_reg(input logic [7:0] g);
		logic [7:0] e;
		e = (rd_q.size() > 0) ? rd_q.pop_front() : 8'hxx;
		n_tests++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %0t register read %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmp_len(input int g);
		int e;
		e = (len_q.size() > 0) ? len_q.pop_front() : -100000;
		n_tests++;
		if (g < e - tol || g > e + tol)
		begin
			miscompares++;
			$display("MISMATCH %0t drive length %0d expected %0d", $time, g, e);
		end
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		rd_q.push_back(e);
		i_host.rd(a, got);
		->rd_ev;
	endtask
	// Lengths of 2 clk or less are zero phases and are not noted
	task automatic seq(input int f, input int r, input int w);
		if (f > 2)
			len_q.push_back(f);
		if (r > 2)
			len_q.push_back(r);
		trig = 1'b1;
		hold(20);
		trig = 1'b0;
		hold(w);
	endtask
	always @(rd_ev)
		cmp_reg(got);
	always @(posedge clk_sys_in)
		if (xrun)
			xc <= #1 !xc;
	always @(posedge clk_sys_in)
	begin
		cyc <= cyc + 1;
		if (cyc > 60000)
		begin
			miscompares++;
			give_verdict();
		end
		if ({p_oe, p, m} === prev)
			run <= run + 1;
		else
		begin
			if (prev[2] && run > 2)
				cmp_len(run);
			run <= 1;
		end
		prev <= {p_oe, p, m};
	end
	initial
	begin
		#1 resetn_in = 1'b0;
		hold(2);
		resetn_in = 1'b1;
		hold(4);
		for (int i = 0; i < 6; i++)
			chk_rd(i[7:0], dflt[i]);
		i_host.wr(8'h00, 8'he9);
		chk_rd(8'h00, 8'h01);
		i_host.wr(8'h06, 8'hff);
		chk_rd(8'h06, 8'h00);
		for (int i = 1; i < 6; i++)
		begin
			lfsr = nxt(lfsr);
			i_host.wr(i[7:0], lfsr[7:0]);
			chk_rd(i[7:0], lfsr[7:0] & msk[i]);
			i_host.wr(i[7:0], dflt[i]);
		end
		$display("test 1 done");
		seq(20 * TK, 10 * TK, 380);
		seq(0, 0, 400);
		seq(20 * TK, 10 * TK, 700);
		$display("test 2 done");
		i_host.wr(8'h01, 8'h0e);
		i_host.wr(8'h02, 8'h02);
		i_host.wr(8'h03, 8'h01);
		tol = 128 * TK + 2;
		seq(4 * 128 * TK, 2 * 128 * TK, 8400);
		i_host.wr(8'h01, 8'h00);
		tol = TK + 2;
		i_host.wr(8'h02, 8'h0a);
		i_host.wr(8'h03, 8'h85);
		xrun = 1'b1;
		i_host.wr(8'h01, 8'h01);
		seq(40, 20, 150);
		len_q.push_back(63);
		trig = 1'b1;
		hold(20);
		trig = 1'b0;
		xrun = 1'b0;
		hold(100);
		i_host.wr(8'h01, 8'h00);
		$display("test 3 done");
		i_host.wr(8'h00, 8'h00);
		vib = 1'b1;
		seq(0, 0, 100);
		vib = 1'b0;
		i_host.wr(8'h00, 8'h01);
		len_q.push_back(300);
		vib = 1'b1;
		hold(300);
		vib = 1'b0;
		len_q.push_back(20 * TK);
		len_q.push_back(10 * TK);
		i_host.wr(8'h00, 8'h03);
		hold(700);
		i_host.wr(8'h00, 8'h01);
		len_q.push_back(20 * TK);
		len_q.push_back(10 * TK);
		len_q.push_back(20 * TK);
		len_q.push_back(10 * TK);
		i_host.wr(8'h00, 8'h11);
		hold(700);
		i_host.wr(8'h00, 8'h01);
		hold(300);
		$display("test 4 done");
		len_q.push_back(100);
		len_q.push_back(100);
		len_q.push_back(100);
		vib = 1'b1;
		hold(100);
		ot = 1'b1;
		hold(20);
		ot = 1'b0;
		hold(100);
		uv = 1'b1;
		hold(20);
		uv = 1'b0;
		hold(100);
		vib = 1'b0;
		hold(20);
		chk_rd(8'h00, 8'h09);
		i_host.wr(8'h00, 8'h01);
		chk_rd(8'h00, 8'h09);
		resetn_in = 1'b0;
		hold(2);
		resetn_in = 1'b1;
		hold(4);
		chk_rd(8'h00, 8'h01);
		$display("test 5 done");
		hold(10);
		give_verdict();
	end
endmodule
